// file: verilog/usbd_ctrl.sv
// usb device address, power management and interrupt pending logic
//
// Overview of operation
// R1: word registers, reserved bits read zero
// R2: software programs registers after host reset
// R3: seven-bit address written, used for tokens
// R4: update flag set by software, cleared on last-packet
// R5: clock mask gates clock, soft reset clears
// R6: soft reset bit holds usb logic reset
// R7: flush bit empties control endpoint fifo
// R8: bus reset bit follows host reset signaling
// R9: wake request drives resume, then clears
// R10: suspended flag set on suspend, cleared resume
// R11: suspend allow bit gates suspend entry
// R12: pending bits clear only by writing one
// R13: crc or stuffing error sets error pending
// R14: bus reset or soft reset sets reset
// R15: bus resume sets resume pending, resume before reset
// R16: suspend pending every 3ms idle, unless gated
// R17: suspend interrupt masked after reset
// R18: receive endpoint events set their pending bits
// R19: transmit endpoint events set their pending bits
// R20: control endpoint events set control pending
// R21: resume length five bits in ms, reset 10
// R22: mask suppresses all but resume interrupt
// R23: ignore other addresses, zero after reset
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module usbd_ctrl #(
   parameter int IDLE_CYCLES = usbd_pkg::IDLE_CYCLES,
   parameter int MS_CYCLES = usbd_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // register port
   input wire usbd_pkg::usbd_bus_req_type i_bus,
   output logic [31:0] o_rdata,
   // bus line pins
   input wire logic i_bus_reset_pin,
   input wire logic i_bus_active_pin,
   input wire logic i_bus_resume_pin,
   input wire logic i_bus_power_pin,
   // serial engine and endpoint events
   input wire logic i_crc_err,
   input wire logic i_stuff_err,
   input wire logic i_token_valid,
   input wire logic [6:0] i_token_addr,
   input wire usbd_pkg::usbd_ep_evt_type i_ep_evt,
   // outputs
   output logic o_token_match,
   output logic o_clk_gate,
   output logic o_soft_rst,
   output logic o_ctrl_fifo_flush,
   output logic o_resume_drive,
   output logic o_suspended,
   output logic o_irq
);

   // reset release
   logic rst_meta_q;
   logic rst_b_q;

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_b_q <= rst_meta_q;
      end
   end

   // pin synchronisers
   logic [3:0] pin_meta_q;
   logic [3:0] pin_q;
   logic bus_reset_s;
   logic bus_active_s;
   logic bus_resume_s;
   logic bus_power_s;

   always_ff @(posedge i_core_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         pin_meta_q <= 4'h0;
         pin_q <= 4'h0;
      end else begin
         pin_meta_q <= {i_bus_power_pin, i_bus_resume_pin, i_bus_active_pin, i_bus_reset_pin};
         pin_q <= pin_meta_q;
      end
   end

   assign bus_reset_s = pin_q[0];
   assign bus_active_s = pin_q[1];
   assign bus_resume_s = pin_q[2];
   assign bus_power_s = pin_q[3];

   // address decode
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
      hit = (a == base);
   endfunction

   wire wr_addr = i_bus.wr && hit(i_bus.addr, usbd_pkg::ADDR_DEV_ADDR);
   wire wr_pwr = i_bus.wr && hit(i_bus.addr, usbd_pkg::ADDR_PWR);
   wire wr_pend = i_bus.wr && hit(i_bus.addr, usbd_pkg::ADDR_INT_PEND);
   wire wr_mask = i_bus.wr && hit(i_bus.addr, usbd_pkg::ADDR_INT_MASK);
   wire wr_rlen = i_bus.wr && hit(i_bus.addr, usbd_pkg::ADDR_RESUME_LEN);
   wire [31:0] wd = i_bus.wdata;

   // registers
   logic [6:0] dev_addr_q;
   logic addr_update_q;
   logic clk_mask_q;
   logic soft_rst_q;
   logic flush_q;
   logic bus_reset_q;
   logic wake_req_q;
   logic susp_allow_q;
   logic [8:0] pend_q;
   logic [8:0] pend_d;
   logic [9:0] mask_q;
   logic [4:0] rlen_q;
   logic [4:0] ms_left_q;
   logic reset_late_q;
   logic bus_reset_prev_q;
   logic bus_resume_prev_q;
   usbd_pkg::usbd_resume_state_type rs_q;
   usbd_pkg::usbd_resume_state_type rs_d;

   // usb side held while soft reset is set
   wire usb_run = !soft_rst_q; // R6
   wire soft_rst_set = wr_pwr && wd[usbd_pkg::PW_SOFT_RST_BIT];

   // timers
   logic idle_tick;
   logic ms_tick;
   wire driving = (rs_q == usbd_pkg::RS_DRIVE);
   wire drive_start = rs_q == usbd_pkg::RS_SUSPENDED && rs_d == usbd_pkg::RS_DRIVE;

   usbd_tick_timer #(
      .PERIOD(IDLE_CYCLES),
      .W(usbd_pkg::TIMER_W)
   ) u_idle (
      .i_core_clk(i_core_clk),
      .i_rst_b(rst_b_q),
      .i_restart(bus_active_s || bus_reset_s || !usb_run),
      .i_enable(!clk_mask_q && !driving), // R16
      .o_tick(idle_tick)
   );

   usbd_tick_timer #(
      .PERIOD(MS_CYCLES),
      .W(usbd_pkg::TIMER_W)
   ) u_ms (
      .i_core_clk(i_core_clk),
      .i_rst_b(rst_b_q),
      .i_restart(!driving && !drive_start),
      .i_enable(driving || drive_start),
      .o_tick(ms_tick)
   );

   // bus edges
   wire bus_reset_rise = bus_reset_s && !bus_reset_prev_q;
   wire bus_resume_rise = bus_resume_s && !bus_resume_prev_q;
   wire suspended = (rs_q != usbd_pkg::RS_AWAKE);

   // suspend and resume sequencing
   wire enter_susp = idle_tick && susp_allow_q; // R11
   wire rlen_zero = (rlen_q == 5'h00);
   wire drive_done = driving && ms_tick && (ms_left_q <= 5'h01);

   always_comb begin
      rs_d = rs_q;
      case (rs_q)
         usbd_pkg::RS_AWAKE: begin
            if (enter_susp) begin
               rs_d = usbd_pkg::RS_SUSPENDED; // R10
            end
         end
         usbd_pkg::RS_SUSPENDED: begin
            if (bus_resume_rise || bus_reset_rise) begin
               rs_d = usbd_pkg::RS_AWAKE; // R10
            end else if (wake_req_q) begin
               rs_d = rlen_zero ? usbd_pkg::RS_AWAKE : usbd_pkg::RS_DRIVE; // R9
            end
         end
         usbd_pkg::RS_DRIVE: begin
            if (drive_done || bus_reset_rise) begin
               rs_d = usbd_pkg::RS_AWAKE; // R9
            end
         end
         default: begin
            rs_d = usbd_pkg::RS_AWAKE;
         end
      endcase
   end

   // pending events
   wire [8:0] pend_set;
   wire bus_resume_evt = (rs_q == usbd_pkg::RS_SUSPENDED) && (bus_resume_rise || bus_reset_rise);

   assign pend_set[usbd_pkg::IP_ERROR_BIT] = i_crc_err || i_stuff_err; // R13
   assign pend_set[usbd_pkg::IP_RESET_BIT] = (bus_reset_rise && !suspended) || reset_late_q || soft_rst_set; // R14
   assign pend_set[usbd_pkg::IP_RESUME_BIT] = bus_resume_evt; // R15
   assign pend_set[usbd_pkg::IP_SUSPEND_BIT] = idle_tick; // R16

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ep
         assign pend_set[usbd_pkg::IP_RX_LSB + g] = i_ep_evt.rx_waiting_set[g] || i_ep_evt.rx_stall_sent[g]; // R18
         assign pend_set[usbd_pkg::IP_TX_LSB + g] = i_ep_evt.tx_loaded_clr[g] || i_ep_evt.tx_flushed[g]; // R19
      end
   endgenerate

   assign pend_set[usbd_pkg::IP_CTRL_BIT] = i_ep_evt.ctrl_rx_waiting_set || i_ep_evt.ctrl_tx_loaded_clr ||
      i_ep_evt.ctrl_stall_sent || i_ep_evt.ctrl_setup_end || i_ep_evt.ctrl_last_clr; // R20

   // set wins over a same-cycle clear
   wire [8:0] pend_clr = wr_pend ? wd[8:0] : 9'h000; // R12
   assign pend_d = (pend_q & ~pend_clr) | pend_set; // R12

   // interrupt output
   wire [8:0] mask_eff;
   assign mask_eff = {mask_q[usbd_pkg::IM_CRC_BIT] && mask_q[usbd_pkg::IM_STUFF_BIT], mask_q[7],
      1'b0, mask_q[5:0]}; // R22
   wire irq_d = |(pend_q & ~mask_eff); // R22

   // token address match
   wire token_hit = i_token_valid && (i_token_addr == dev_addr_q) && usb_run; // R23

   // register process: device address
   always_ff @(posedge i_core_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         dev_addr_q <= usbd_pkg::RST_DEV_ADDR[6:0];
         addr_update_q <= usbd_pkg::RST_DEV_ADDR[usbd_pkg::DA_UPDATE_BIT];
      end else begin
         if (wr_addr) begin
            dev_addr_q <= wd[usbd_pkg::DA_ADDR_LSB +: usbd_pkg::DA_ADDR_W]; // R3
         end
         if (wr_addr && wd[usbd_pkg::DA_UPDATE_BIT]) begin
            addr_update_q <= 1'b1; // R4
         end else if (i_ep_evt.ctrl_last_set) begin
            addr_update_q <= 1'b0; // R4
         end
      end
   end

   // register process: power management controls
   always_ff @(posedge i_core_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         clk_mask_q <= usbd_pkg::RST_PWR[usbd_pkg::PW_CLK_MASK_BIT];
         soft_rst_q <= usbd_pkg::RST_PWR[usbd_pkg::PW_SOFT_RST_BIT];
         flush_q <= usbd_pkg::RST_PWR[usbd_pkg::PW_FLUSH_BIT];
         susp_allow_q <= usbd_pkg::RST_PWR[usbd_pkg::PW_SUSP_ALLOW_BIT];
      end else begin
         if (soft_rst_set) begin
            clk_mask_q <= 1'b0; // R5
         end else if (wr_pwr) begin
            clk_mask_q <= wd[usbd_pkg::PW_CLK_MASK_BIT]; // R5
         end
         if (wr_pwr) begin
            soft_rst_q <= wd[usbd_pkg::PW_SOFT_RST_BIT]; // R6
            susp_allow_q <= wd[usbd_pkg::PW_SUSP_ALLOW_BIT]; // R11
         end
         flush_q <= wr_pwr && wd[usbd_pkg::PW_FLUSH_BIT]; // R7
      end
   end

   // usb side state
   always_ff @(posedge i_core_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         rs_q <= usbd_pkg::RS_AWAKE;
         wake_req_q <= 1'b0;
         ms_left_q <= 5'h00;
         bus_reset_q <= 1'b0;
         bus_reset_prev_q <= 1'b0;
         bus_resume_prev_q <= 1'b0;
         reset_late_q <= 1'b0;
      end else if (!usb_run) begin
         rs_q <= usbd_pkg::RS_AWAKE; // R6
         wake_req_q <= 1'b0;
         ms_left_q <= 5'h00;
         bus_reset_q <= 1'b0;
         bus_reset_prev_q <= bus_reset_s;
         bus_resume_prev_q <= bus_resume_s;
         reset_late_q <= 1'b0;
      end else begin
         rs_q <= rs_d;
         bus_reset_q <= bus_reset_s; // R8
         bus_reset_prev_q <= bus_reset_s;
         bus_resume_prev_q <= bus_resume_s;
         reset_late_q <= bus_reset_rise && suspended; // R15
         if (drive_start) begin
            ms_left_q <= rlen_q; // R21
         end else if (ms_tick && ms_left_q != 5'h00) begin
            ms_left_q <= ms_left_q - 5'h01; // R21
         end
         if (rs_d == usbd_pkg::RS_AWAKE && rs_q != usbd_pkg::RS_AWAKE) begin
            wake_req_q <= 1'b0; // R9
         end else if (wr_pwr && wd[usbd_pkg::PW_WAKE_REQ_BIT] && rs_q == usbd_pkg::RS_SUSPENDED) begin
            wake_req_q <= 1'b1; // R9
         end
      end
   end

   // interrupt registers and resume length
   always_ff @(posedge i_core_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         pend_q <= usbd_pkg::RST_INT_PEND;
         mask_q <= usbd_pkg::RST_INT_MASK; // R17
         rlen_q <= usbd_pkg::RST_RESUME_LEN; // R21
      end else begin
         pend_q <= pend_d;
         if (wr_mask) begin
            mask_q <= wd[usbd_pkg::IM_W-1:0];
         end
         if (wr_rlen) begin
            rlen_q <= wd[usbd_pkg::RESUME_LEN_W-1:0];
         end
      end
   end

   // read data, zero above each field
   wire [31:0] rd_pwr = {23'h00_0000, clk_mask_q, 1'b0, 1'b0, bus_power_s, 1'b0, bus_reset_q,
      wake_req_q, suspended, susp_allow_q}; // R1
   wire [31:0] rd_mux =
      hit(i_bus.addr, usbd_pkg::ADDR_DEV_ADDR) ? {24'h00_0000, addr_update_q, dev_addr_q} :
      hit(i_bus.addr, usbd_pkg::ADDR_PWR) ? rd_pwr :
      hit(i_bus.addr, usbd_pkg::ADDR_INT_PEND) ? {23'h00_0000, pend_q} :
      hit(i_bus.addr, usbd_pkg::ADDR_INT_MASK) ? {22'h00_0000, mask_q} :
      hit(i_bus.addr, usbd_pkg::ADDR_RESUME_LEN) ? {27'h000_0000, rlen_q} : 32'h0000_0000; // R1

   // outputs
   always_ff @(posedge i_core_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         o_rdata <= 32'h0000_0000;
         o_token_match <= 1'b0;
         o_clk_gate <= 1'b0;
         o_soft_rst <= 1'b0;
         o_ctrl_fifo_flush <= 1'b0;
         o_resume_drive <= 1'b0;
         o_suspended <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_rdata <= i_bus.rd ? rd_mux : 32'h0000_0000;
         o_token_match <= token_hit; // R23
         o_clk_gate <= clk_mask_q; // R5
         o_soft_rst <= soft_rst_q; // R6
         o_ctrl_fifo_flush <= flush_q; // R7
         o_resume_drive <= (rs_d == usbd_pkg::RS_DRIVE); // R9
         o_suspended <= (rs_d != usbd_pkg::RS_AWAKE); // R10
         o_irq <= irq_d;
      end
   end

endmodule

// file: verilog/usbd_pkg.sv
// constants and types of the usb device control and status block
package usbd_pkg;

   // register byte addresses
   localparam logic [31:0] ADDR_DEV_ADDR = 32'h1520_0140;
   localparam logic [31:0] ADDR_PWR = 32'h1520_0144;
   localparam logic [31:0] ADDR_INT_PEND = 32'h1520_0148;
   localparam logic [31:0] ADDR_INT_MASK = 32'h1520_014C;
   localparam logic [31:0] ADDR_RESUME_LEN = 32'h1520_0154;

   // device_address fields
   localparam int DA_ADDR_LSB = 0;
   localparam int DA_ADDR_W = 7;
   localparam int DA_UPDATE_BIT = 7;

   // power_management fields
   localparam int PW_CLK_MASK_BIT = 8;
   localparam int PW_SOFT_RST_BIT = 7;
   localparam int PW_FLUSH_BIT = 6;
   localparam int PW_BUS_POWER_BIT = 5;
   localparam int PW_BUS_RESET_BIT = 3;
   localparam int PW_WAKE_REQ_BIT = 2;
   localparam int PW_SUSPENDED_BIT = 1;
   localparam int PW_SUSP_ALLOW_BIT = 0;

   // interrupt_pending fields
   localparam int IP_ERROR_BIT = 8;
   localparam int IP_RESET_BIT = 7;
   localparam int IP_RESUME_BIT = 6;
   localparam int IP_SUSPEND_BIT = 5;
   localparam int IP_RX_LSB = 3;
   localparam int IP_TX_LSB = 1;
   localparam int IP_CTRL_BIT = 0;
   localparam int IP_W = 9;

   // interrupt mask fields
   localparam int IM_W = 10;
   localparam int IM_CRC_BIT = 9;
   localparam int IM_STUFF_BIT = 8;

   // reset values
   localparam logic [31:0] RST_DEV_ADDR = 32'h0000_0000;
   localparam logic [31:0] RST_PWR = 32'h0000_0000;
   localparam logic [8:0] RST_INT_PEND = 9'h000;
   localparam logic [9:0] RST_INT_MASK = 10'h33F;
   localparam logic [4:0] RST_RESUME_LEN = 5'h0A;
   localparam int RESUME_LEN_W = 5;

   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int IDLE_TIME_US = 3000;
   localparam int MS_TIME_US = 1000;
   localparam int IDLE_CYCLES = CLK_HZ / 1_000_000 * IDLE_TIME_US;
   localparam int MS_CYCLES = CLK_HZ / 1_000_000 * MS_TIME_US;
   localparam int TIMER_W = 16;

   // register port request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } usbd_bus_req_type;

   // endpoint event pulses from the endpoint logic
   typedef struct packed {
      logic [1:0] rx_waiting_set;
      logic [1:0] rx_stall_sent;
      logic [1:0] tx_loaded_clr;
      logic [1:0] tx_flushed;
      logic ctrl_rx_waiting_set;
      logic ctrl_tx_loaded_clr;
      logic ctrl_stall_sent;
      logic ctrl_setup_end;
      logic ctrl_last_clr;
      logic ctrl_last_set;
   } usbd_ep_evt_type;

   typedef enum logic [1:0] {
      RS_AWAKE,
      RS_SUSPENDED,
      RS_DRIVE
   } usbd_resume_state_type;

endpackage

// file: verilog/usbd_tick_timer.sv
// reloading down counter that pulses once per period
`timescale 1ns/1ns
module usbd_tick_timer #(
   parameter int PERIOD = 10,
   parameter int W = 16
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // control
   input wire logic i_restart,
   input wire logic i_enable,
   // tick
   output logic o_tick
);

   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic tick_d;

   generate
      if (PERIOD < 2 || PERIOD > (2 ** W) - 1) begin : g_bad
         $error("timer period out of range");
      end
   endgenerate

   // count down, reload at zero
   assign tick_d = i_enable && !i_restart && (cnt_q == '0);
   assign cnt_d = (i_restart || tick_d) ? LAST : (i_enable ? cnt_q - 1'b1 : cnt_q);

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= LAST;
         o_tick <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         o_tick <= tick_d;
      end
   end

endmodule

// file: testbench/usbd_ctrl_sva.sv
// port assertions of the usb device control block
`timescale 1ns/1ns
module usbd_ctrl_sva #(
   parameter int IDLE_CYCLES = 20,
   parameter int MS_CYCLES = 4
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // inputs
   input wire usbd_pkg::usbd_bus_req_type i_bus,
   input wire logic i_bus_active_pin,
   input wire logic i_bus_resume_pin,
   input wire logic i_token_valid,
   input wire logic [6:0] i_token_addr,
   // outputs
   input wire logic [31:0] o_rdata,
   input wire logic o_token_match,
   input wire logic o_clk_gate,
   input wire logic o_soft_rst,
   input wire logic o_ctrl_fifo_flush,
   input wire logic o_resume_drive,
   input wire logic o_suspended,
   input wire logic o_irq
);
   logic [6:0] addr_q;
   logic [4:0] rlen_q;
   logic allow_q;
   int drive_q;
   int idle_q;
   wire wr_pw = i_bus.wr && i_bus.addr == usbd_pkg::ADDR_PWR;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         addr_q <= 7'h00;
         rlen_q <= usbd_pkg::RST_RESUME_LEN;
         allow_q <= 1'b0;
         drive_q <= 0;
         idle_q <= 0;
      end else begin
         if (i_bus.wr && i_bus.addr == usbd_pkg::ADDR_DEV_ADDR) addr_q <= i_bus.wdata[6:0];
         if (i_bus.wr && i_bus.addr == usbd_pkg::ADDR_RESUME_LEN) rlen_q <= i_bus.wdata[4:0];
         if (wr_pw) allow_q <= i_bus.wdata[0];
         drive_q <= o_resume_drive ? drive_q + 1 : 0;
         idle_q <= i_bus_active_pin ? 0 : idle_q + 1;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_wake_req;
      wr_pw && i_bus.wdata[2] && o_suspended && rlen_q != 5'h00;
   endsequence
   sequence s_drive_end;
      o_resume_drive ##1 !o_resume_drive;
   endsequence
   property p_reserved;
      i_bus.rd && i_bus.addr == usbd_pkg::ADDR_PWR |=> o_rdata[31:9] == 23'h0 && o_rdata[7:6] == 2'h0 && !o_rdata[4];
   endproperty
   property p_token_hit;
      i_token_valid && i_token_addr == addr_q && !o_soft_rst |=> o_token_match;
   endproperty
   property p_token_miss;
      i_token_valid && i_token_addr != addr_q |=> !o_token_match;
   endproperty
   property p_clk_gate;
      logic v;
      (wr_pw, v = i_bus.wdata[8] & ~i_bus.wdata[7]) |-> ##2 o_clk_gate == v;
   endproperty
   property p_soft_rst;
      logic v;
      (wr_pw, v = i_bus.wdata[7]) |-> ##2 o_soft_rst == v;
   endproperty
   property p_flush;
      wr_pw && i_bus.wdata[6] |-> ##2 o_ctrl_fifo_flush;
   endproperty
   property p_wake;
      s_wake_req |-> ##[1:2] o_resume_drive;
   endproperty
   property p_drive_len;
      s_drive_end |-> drive_q == rlen_q * MS_CYCLES ##[0:1] !o_suspended;
   endproperty
   property p_resume_irq;
      o_suspended && $rose(i_bus_resume_pin) |-> ##[2:8] o_irq;
   endproperty
   property p_suspend_entry;
      $rose(o_suspended) |-> allow_q && idle_q >= IDLE_CYCLES;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved power bits not zero");
   a_token_hit: assert property (p_token_hit) else $error("token for own address not matched");
   a_token_miss: assert property (p_token_miss) else $error("token for other address matched");
   a_clk_gate: assert property (p_clk_gate) else $error("clock gate wrong after write");
   a_soft_rst: assert property (p_soft_rst) else $error("soft reset wrong after write");
   a_flush: assert property (p_flush) else $error("no fifo flush pulse");
   a_wake: assert property (p_wake) else $error("wake request did not drive resume");
   a_drive_len: assert property (p_drive_len) else $error("resume drive length wrong");
   a_resume_irq: assert property (p_resume_irq) else $error("resume interrupt missing");
   a_suspend_entry: assert property (p_suspend_entry) else $error("suspend entered early");
endmodule

bind usbd_ctrl usbd_ctrl_sva #(.IDLE_CYCLES(IDLE_CYCLES), .MS_CYCLES(MS_CYCLES)) u_sva (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_bus(i_bus), .i_bus_active_pin(i_bus_active_pin),
   .i_bus_resume_pin(i_bus_resume_pin), .i_token_valid(i_token_valid), .i_token_addr(i_token_addr),
   .o_rdata(o_rdata), .o_token_match(o_token_match), .o_clk_gate(o_clk_gate), .o_soft_rst(o_soft_rst),
   .o_ctrl_fifo_flush(o_ctrl_fifo_flush), .o_resume_drive(o_resume_drive), .o_suspended(o_suspended),
   .o_irq(o_irq));

// file: testbench/usbd_host_model.sv
// behavioural usb host driving the bus-side pins
`timescale 1ns/1ns
module usbd_host_model (
   // clock
   input wire logic i_core_clk,
   // bus pins and decoded tokens
   output logic o_bus_reset_pin,
   output logic o_bus_active_pin,
   output logic o_bus_resume_pin,
   output logic o_bus_power_pin,
   output logic o_token_valid,
   output logic [6:0] o_token_addr
);
   initial begin
      o_bus_reset_pin = 1'b0;
      o_bus_active_pin = 1'b1;
      o_bus_resume_pin = 1'b0;
      o_bus_power_pin = 1'b1;
      o_token_valid = 1'b0;
      o_token_addr = 7'h7F;
   end
   task automatic bus_reset(input int n);
      @(posedge i_core_clk);
      o_bus_reset_pin <= 1'b1;
      repeat (n) @(posedge i_core_clk);
      o_bus_reset_pin <= 1'b0;
   endtask
   task automatic resume(input int n);
      @(posedge i_core_clk);
      o_bus_resume_pin <= 1'b1;
      repeat (n) @(posedge i_core_clk);
      o_bus_resume_pin <= 1'b0;
   endtask
   task automatic set_active(input logic v, input logic p = 1'b1);
      @(posedge i_core_clk);
      o_bus_active_pin <= v;
      o_bus_power_pin <= p;
   endtask
   // address field toggles once the token is gone
   task automatic token(input logic [6:0] a);
      @(posedge i_core_clk);
      o_token_valid <= 1'b1;
      o_token_addr <= a;
      @(posedge i_core_clk);
      o_token_valid <= 1'b0;
      o_token_addr <= ~a;
   endtask
endmodule

// file: testbench/usb_device_addr_power_irq_bench.sv
// self-checking bench of the usb device control block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module usb_device_addr_power_irq_bench;
   logic i_core_clk = 1'b0;
   logic i_rst_b = 1'b0;
   usbd_pkg::usbd_bus_req_type bus;
   usbd_pkg::usbd_ep_evt_type evt;
   logic crc_err;
   logic stuff_err;
   wire rst_pin, act_pin, res_pin, pwr_pin, tok_v, match, gate, srst, flush, drive, susp, irq;
   wire [6:0] tok_a;
   wire [31:0] rdata;
   logic [31:0] rd_q;
   int bad_count = 0;
   int checks = 0;
   usbd_host_model host (.i_core_clk(i_core_clk), .o_bus_reset_pin(rst_pin), .o_bus_active_pin(act_pin),
      .o_bus_resume_pin(res_pin), .o_bus_power_pin(pwr_pin), .o_token_valid(tok_v), .o_token_addr(tok_a));
   usbd_ctrl #(.IDLE_CYCLES(20), .MS_CYCLES(4)) DUT (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_bus(bus),
      .o_rdata(rdata), .i_bus_reset_pin(rst_pin), .i_bus_active_pin(act_pin), .i_bus_resume_pin(res_pin),
      .i_bus_power_pin(pwr_pin), .i_crc_err(crc_err), .i_stuff_err(stuff_err), .i_token_valid(tok_v),
      .i_token_addr(tok_a), .i_ep_evt(evt), .o_token_match(match), .o_clk_gate(gate), .o_soft_rst(srst),
      .o_ctrl_fifo_flush(flush), .o_resume_drive(drive), .o_suspended(susp), .o_irq(irq));
   always #50 i_core_clk = ~i_core_clk;
   task automatic step;
      @(posedge i_core_clk);
      #1;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge i_core_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rc(input logic [31:0] a, input logic [31:0] e, input string n);
      @(posedge i_core_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge i_core_clk);
      bus.rd <= 1'b0;
      #1 rd_q = rdata;
      `CHK(n, e, rd_q)
   endtask
   task automatic t_reset_values;
      rc(usbd_pkg::ADDR_DEV_ADDR, 32'h0000_0000, "device_address");
      rc(usbd_pkg::ADDR_PWR, 32'h0000_0020, "power_management");
      rc(usbd_pkg::ADDR_INT_PEND, 32'h0000_0000, "interrupt_pending");
      rc(usbd_pkg::ADDR_INT_MASK, 32'h0000_033F, "interrupt_mask");
      rc(usbd_pkg::ADDR_RESUME_LEN, 32'h0000_000A, "resume_length");
      rc(32'h1520_0158, 32'h0000_0000, "unmapped");
      $display("test reset_values done");
   endtask
   task automatic t_addr_token;
      fork
         host.bus_reset(10);
         begin
            repeat (7) step;
            rc(usbd_pkg::ADDR_PWR, 32'h0000_0028, "bus_reset_bit");
         end
      join
      repeat (4) step;
      rc(usbd_pkg::ADDR_PWR, 32'h0000_0020, "bus_reset_end");
      wr(usbd_pkg::ADDR_INT_PEND, 32'h0000_0000);
      rc(usbd_pkg::ADDR_INT_PEND, 32'h0000_0080, "reset_pending");
      wr(usbd_pkg::ADDR_INT_PEND, 32'h0000_0080);
      rc(usbd_pkg::ADDR_INT_PEND, 32'h0000_0000, "pending_cleared");
      wr(usbd_pkg::ADDR_DEV_ADDR, 32'h0000_0085);
      rc(usbd_pkg::ADDR_DEV_ADDR, 32'h0000_0085, "address_update");
      host.token(7'h05);
      #1 `CHK("own_token", 1'b1, match)
      host.token(7'h00);
      #1 `CHK("other_token", 1'b0, match)
      @(posedge i_core_clk);
      evt <= usbd_pkg::usbd_ep_evt_type'(14'h0001);
      @(posedge i_core_clk);
      evt <= '0;
      rc(usbd_pkg::ADDR_DEV_ADDR, 32'h0000_0005, "update_cleared");
      $display("test addr_token done");
   endtask
   task automatic t_events;
      logic [31:0] e;
      for (int i = 1; i < 16; i++) begin
         @(posedge i_core_clk);
         if (i < 14) evt <= usbd_pkg::usbd_ep_evt_type'(14'h0001 << i);
         crc_err <= (i == 14);
         stuff_err <= (i == 15);
         @(posedge i_core_clk);
         evt <= '0;
         crc_err <= 1'b0;
         stuff_err <= 1'b0;
         e = i > 13 ? 32'h0000_0100 : i > 9 ? 32'h0000_0008 << i % 2 : i > 5 ? 32'h0000_0002 << i % 2 : 32'h0000_0001;
         rc(usbd_pkg::ADDR_INT_PEND, e, "event_pending");
         wr(usbd_pkg::ADDR_INT_PEND, 32'h0000_01FF);
      end
      $display("test events done");
   endtask
   task automatic t_power;
      wr(usbd_pkg::ADDR_PWR, 32'h0000_0100);
      step;
      `CHK("clock_gate", 1'b1, gate)
      wr(usbd_pkg::ADDR_PWR, 32'h0000_0180);
      step;
      `CHK("gate_cleared", 1'b0, gate)
      `CHK("soft_reset", 1'b1, srst)
      rc(usbd_pkg::ADDR_INT_PEND, 32'h0000_0080, "soft_reset_pending");
      wr(usbd_pkg::ADDR_PWR, 32'h0000_0000);
      step;
      `CHK("soft_reset_off", 1'b0, srst)
      wr(usbd_pkg::ADDR_INT_PEND, 32'h0000_01FF);
      wr(usbd_pkg::ADDR_PWR, 32'h0000_0040);
      step;
      `CHK("fifo_flush", 1'b1, flush)
      rc(usbd_pkg::ADDR_PWR, 32'h0000_0020, "flush_reads_zero");
      host.set_active(1'b1, 1'b0);
      step;
      rc(usbd_pkg::ADDR_PWR, 32'h0000_0000, "power_off");
      $display("test power done");
   endtask
   task automatic t_suspend;
      int n;
      host.set_active(1'b0);
      repeat (60) step;
      `CHK("no_suspend", 1'b0, susp)
      wr(usbd_pkg::ADDR_INT_PEND, 32'h0000_01FF);
      wr(usbd_pkg::ADDR_PWR, 32'h0000_0001);
      for (n = 0; n < 80 && susp !== 1'b1; n++) step;
      `CHK("suspended", 1'b1, susp)
      rc(usbd_pkg::ADDR_INT_PEND, 32'h0000_0020, "suspend_pending");
      `CHK("suspend_masked", 1'b0, irq)
      wr(usbd_pkg::ADDR_RESUME_LEN, 32'h0000_0002);
      wr(usbd_pkg::ADDR_PWR, 32'h0000_0005);
      for (n = 0; n < 20 && drive !== 1'b1; n++) step;
      for (n = 0; n < 100 && drive === 1'b1; n++) step;
      `CHK("drive_cycles", 8, n)
      step;
      `CHK("awake", 1'b0, susp)
      rc(usbd_pkg::ADDR_PWR, 32'h0000_0021, "wake_cleared");
      for (n = 0; n < 80 && susp !== 1'b1; n++) step;
      wr(usbd_pkg::ADDR_INT_PEND, 32'h0000_01FF);
      host.resume(8);
      for (n = 0; n < 10 && irq !== 1'b1; n++) step;
      `CHK("resume_irq", 1'b1, irq)
      `CHK("bus_wake", 1'b0, susp)
      rc(usbd_pkg::ADDR_INT_PEND, 32'h0000_0040, "resume_pending");
      host.set_active(1'b1);
      $display("test suspend done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      {bus, evt, crc_err, stuff_err} <= '0;
      repeat (4) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      t_reset_values;
      t_addr_token;
      t_events;
      t_power;
      t_suspend;
      complete_run;
   end
   initial begin
      #500000;
      bad_count++;
      complete_run;
   end
endmodule
